// ==== verilog/cfg_space_consts.svh ====
// offsets, capability codes and reset values of the configuration space
`ifndef CFG_SPACE_CONSTS_SVH
`define CFG_SPACE_CONSTS_SVH

// byte offsets of the capability chain
`define OFF_ID 12'h000
`define OFF_CAP_PTR 12'h034
`define OFF_PM_CAP 12'h040
`define OFF_MSI_CAP 12'h048
`define OFF_PCIX_CAP 12'h058
`define OFF_PCIE_CAP 12'h068
`define OFF_DSN_CAP 12'h100
`define OFF_PB_CAP 12'h138
`define OFF_VC_CAP 12'h148
`define OFF_AER_CAP 12'hFB4

// byte offsets of the access-type registers
`define OFF_CTRL 12'h200
`define OFF_STICKY_CTRL 12'h204
`define OFF_STATUS 12'h208
`define OFF_STICKY_STATUS 12'h20C
`define OFF_EVENT_COUNT 12'h210
`define OFF_STICKY_LOG 12'h214

// standard capability identifiers and next pointers
`define CAP_ID_PM 8'h01
`define CAP_ID_MSI 8'h05
`define CAP_ID_PCIX 8'h07
`define CAP_ID_PCIE 8'h10
`define NEXT_PM 8'h48
`define NEXT_MSI 8'h68
`define NEXT_PCIX 8'h68
`define NEXT_PCIE 8'h00
`define CAP_PTR_VAL 8'h40
`define STD_HI_ZERO 16'h0000
`define CAP_PTR_HI_ZERO 24'h00_0000

// extended capability identifiers, version and next offsets
`define XCAP_ID_AER 16'h0001
`define XCAP_ID_VC 16'h0002
`define XCAP_ID_DSN 16'h0003
`define XCAP_ID_PB 16'h0004
`define XCAP_VER 4'h1
`define XNEXT_DSN 12'hFB4
`define XNEXT_AER 12'h138
`define XNEXT_PB 12'h148
`define XNEXT_VC 12'h000

// reset values and counter steps
`define ZERO32 32'h0000_0000
`define RST_CTRL 32'h0000_0000
`define RST_STICKY_CTRL 32'h0000_0000
`define CNT_ONE 32'h0000_0001
`define CNT_MAX 32'hFFFF_FFFF

`endif

// ==== verilog/cfg_space_pkg.sv ====
// types shared by the configuration space modules
package cfg_space_pkg;
  typedef logic [31:0] dword_t;
  typedef logic [9:0] dw_index_t;
endpackage

// ==== verilog/cfg_access_if.sv ====
// one accepted configuration access as seen by the helper modules
`timescale 1ns/1ps
interface cfg_access_if;
  logic wr;
  logic rd;
  cfg_space_pkg::dw_index_t dw;
  cfg_space_pkg::dword_t wdata;
  cfg_space_pkg::dword_t mask;
  modport src (output wr, output rd, output dw, output wdata, output mask);
  modport sink (input wr, input rd, input dw, input wdata, input mask);
endinterface

// ==== verilog/cap_header_rom.sv ====
// constant capability headers of the standard and extended chains
`timescale 1ns/1ps
`include "cfg_space_consts.svh"
module cap_header_rom
(
  cfg_access_if.sink acc,
  output wire logic o_hit,
  output cfg_space_pkg::dword_t o_data
);
  localparam int N = 9;
  localparam logic [11:0] OFFS [N] = '{`OFF_CAP_PTR, `OFF_PM_CAP, `OFF_MSI_CAP,
    `OFF_PCIX_CAP, `OFF_PCIE_CAP, `OFF_DSN_CAP, `OFF_AER_CAP, `OFF_PB_CAP,
    `OFF_VC_CAP};
  localparam logic [31:0] DATA [N] = '{
    {`CAP_PTR_HI_ZERO, `CAP_PTR_VAL},
    {`STD_HI_ZERO, `NEXT_PM, `CAP_ID_PM},
    {`STD_HI_ZERO, `NEXT_MSI, `CAP_ID_MSI},
    {`STD_HI_ZERO, `NEXT_PCIX, `CAP_ID_PCIX},
    {`STD_HI_ZERO, `NEXT_PCIE, `CAP_ID_PCIE},
    {`XNEXT_DSN, `XCAP_VER, `XCAP_ID_DSN},
    {`XNEXT_AER, `XCAP_VER, `XCAP_ID_AER},
    {`XNEXT_PB, `XCAP_VER, `XCAP_ID_PB},
    {`XNEXT_VC, `XCAP_VER, `XCAP_ID_VC}};

  logic [N:0] hit_chain;
  logic [31:0] data_chain [N+1];

  assign hit_chain[0] = 1'b0;
  assign data_chain[0] = `ZERO32;

  genvar i;
  generate
    for (i = 0; i < N; i++)
    begin : g_entry
      wire logic entry_hit;
      assign entry_hit = (acc.dw == OFFS[i][11:2]);
      assign hit_chain[i+1] = hit_chain[i] | entry_hit;
      // standard: id 7:0, next 15:8; extended: id 15:0, version 19:16, next 31:20
      assign data_chain[i+1] = data_chain[i] | (entry_hit ? DATA[i] : `ZERO32); // R18
    end
  endgenerate

  // R11 R12 R13 R14 R15 R16 R17
  assign o_hit = hit_chain[N];
  assign o_data = data_chain[N];
endmodule

// ==== verilog/status_w1c_bank.sv ====
// write-one-to-clear status bits, optionally sticky
`timescale 1ns/1ps
`include "cfg_space_consts.svh"
module status_w1c_bank
#(
  parameter int W = 32,
  parameter bit STICKY = 1'b0
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_hot_reset,
  input wire logic i_aux_keep,
  cfg_access_if.sink acc,
  input wire logic i_sel,
  input wire logic [W-1:0] i_set,
  output logic [W-1:0] o_q
);
  wire logic clear_all;
  wire logic wr_hit;
  wire logic [W-1:0] clr_bits;

  // sticky bits ignore hot reset and keep their value while aux power is kept
  assign clear_all = STICKY ? (!i_reset_n && !i_aux_keep) : (!i_reset_n || i_hot_reset); // R7 R9
  assign wr_hit = acc.wr && i_sel;
  assign clr_bits = wr_hit ? (acc.wdata[W-1:0] & acc.mask[W-1:0]) : '0;

  wire logic [W-1:0] nxt_q;

  genvar b;
  generate
    for (b = 0; b < W; b++)
    begin : g_bit
      // a set in the clearing cycle wins; a written zero changes nothing
      assign nxt_q[b] = i_set[b] | (o_q[b] & ~clr_bits[b]); // R6 R7
    end
  endgenerate

  always_ff @(posedge i_sys_clk)
  begin
    if (clear_all)
      o_q <= '0;
    else
      o_q <= nxt_q;
  end
endmodule

// ==== verilog/config_space_capability_chain.sv ====
// configuration space: capability chains and the access-type registers
// Overview of operation
// R1: hardware-initialised bits load once, reset by fundamental
// R2: read-clear counter tallies events, zeroed on read
// R3: read-only bits ignore writes, loadable by initialisation
// R4: sticky read-only bits survive hot reset
// R5: read-write bits store and return written value
// R6: status bits set by events, written one clears
// R7: sticky status: zero ignored, reset leaves them
// R8: sticky read-write bits keep value through reset
// R9: aux power enabled keeps all sticky contents
// R10: loadable registers take eeprom defaults before access
// R11: capability pointer 40h; PM id 01h, next 48h
// R12: PCI-X capability id 07h, next 68h
// R13: PCI Express capability id 10h, next 00h
// R14: serial number: 0003h, version 1h, next FB4h
// R15: power budget: 0004h, version 1h, next 148h
// R16: virtual channel: 0002h, version 1h, next 000h
// R17: error reporting: 0001h, version 1h, next 138h
// R18: standard and extended header field positions fixed
// R19: reserved locations read zero, writes ignored
`timescale 1ns/1ps
`include "cfg_space_consts.svh"
module config_space_capability_chain
#(
  parameter logic [15:0] VENDOR_ID_DEF = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_ID_DEF = 16'h5678, // arbitrary value
  parameter int STATUS_W = 8,
  parameter int STICKY_STATUS_W = 8
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_hot_reset,
  input wire logic i_aux_keep,
  input wire logic i_cfg_req,
  input wire logic i_cfg_wr,
  input wire logic [11:2] i_cfg_addr,
  input wire logic [31:0] i_cfg_wdata,
  input wire logic [3:0] i_cfg_be,
  output logic o_cfg_ready,
  output logic o_cfg_ack,
  output logic [31:0] o_cfg_rdata,
  input wire logic i_eep_load,
  input wire logic [11:2] i_eep_addr,
  input wire logic [31:0] i_eep_data,
  input wire logic i_eep_done,
  input wire logic i_count_evt,
  input wire logic [STATUS_W-1:0] i_status_set,
  input wire logic [STICKY_STATUS_W-1:0] i_sticky_status_set,
  input wire logic i_log_load,
  input wire logic [31:0] i_log_val,
  output logic [31:0] o_ctrl,
  output logic [31:0] o_sticky_ctrl,
  output logic [STATUS_W-1:0] o_status,
  output logic [STICKY_STATUS_W-1:0] o_sticky_status
);
  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  cfg_access_if acc ();

  logic ready_ff;
  logic ack_ff;
  cfg_space_pkg::dword_t rdata_ff;
  cfg_space_pkg::dword_t id_ff;
  cfg_space_pkg::dword_t ctrl_ff;
  cfg_space_pkg::dword_t ctrl_def_ff;
  cfg_space_pkg::dword_t sticky_ctrl_ff;
  cfg_space_pkg::dword_t count_ff;
  cfg_space_pkg::dword_t log_ff;

  wire logic take;
  wire logic nonsticky_clr;
  wire logic sticky_clr;
  wire logic [31:0] be_mask;

  // requests are only taken once the eeprom load has finished
  assign take = i_cfg_req && ready_ff; // R10
  assign be_mask = {{8{i_cfg_be[3]}}, {8{i_cfg_be[2]}}, {8{i_cfg_be[1]}}, {8{i_cfg_be[0]}}};
  assign nonsticky_clr = !i_reset_n || i_hot_reset;
  assign sticky_clr = !i_reset_n && !i_aux_keep; // R4 R8 R9

  assign acc.wr = take && i_cfg_wr;
  assign acc.rd = take && !i_cfg_wr;
  assign acc.dw = i_cfg_addr;
  assign acc.wdata = i_cfg_wdata;
  assign acc.mask = be_mask;

  wire logic sel_id;
  wire logic sel_ctrl;
  wire logic sel_sticky_ctrl;
  wire logic sel_status;
  wire logic sel_sticky_status;
  wire logic sel_count;
  wire logic sel_log;

  // dword addresses widen back to byte offsets so the compares match the map
  wire logic [11:0] cfg_byte;
  wire logic [11:0] eep_byte;

  assign cfg_byte = {i_cfg_addr, 2'h0};
  assign eep_byte = {i_eep_addr, 2'h0};
  assign sel_id = (cfg_byte == `OFF_ID);
  assign sel_ctrl = (cfg_byte == `OFF_CTRL);
  assign sel_sticky_ctrl = (cfg_byte == `OFF_STICKY_CTRL);
  assign sel_status = (cfg_byte == `OFF_STATUS);
  assign sel_sticky_status = (cfg_byte == `OFF_STICKY_STATUS);
  assign sel_count = (cfg_byte == `OFF_EVENT_COUNT);
  assign sel_log = (cfg_byte == `OFF_STICKY_LOG);

  wire logic eep_id;
  wire logic eep_ctrl;

  assign eep_id = i_eep_load && !ready_ff && (eep_byte == `OFF_ID); // R1 R10
  assign eep_ctrl = i_eep_load && !ready_ff && (eep_byte == `OFF_CTRL); // R10

  // ----------------------------------------------------------------
  // capability headers and status banks
  // ----------------------------------------------------------------
  wire logic rom_hit;
  cfg_space_pkg::dword_t rom_data;

  cap_header_rom u_rom
  (
    .acc (acc.sink),
    .o_hit (rom_hit),
    .o_data (rom_data)
  );

  // plain status clears on hot reset; the sticky bank only when power is lost
  status_w1c_bank #(.W(STATUS_W), .STICKY(1'b0)) u_status
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_hot_reset (i_hot_reset),
    .i_aux_keep (i_aux_keep),
    .acc (acc.sink),
    .i_sel (sel_status),
    .i_set (i_status_set),
    .o_q (o_status)
  );

  status_w1c_bank #(.W(STICKY_STATUS_W), .STICKY(1'b1)) u_sticky_status
  (
    .i_sys_clk (i_sys_clk),
    .i_reset_n (i_reset_n),
    .i_hot_reset (i_hot_reset),
    .i_aux_keep (i_aux_keep),
    .acc (acc.sink),
    .i_sel (sel_sticky_status),
    .i_set (i_sticky_status_set),
    .o_q (o_sticky_status)
  );

  // ----------------------------------------------------------------
  // next values
  // ----------------------------------------------------------------
  cfg_space_pkg::dword_t nxt_id;
  cfg_space_pkg::dword_t nxt_ctrl;
  cfg_space_pkg::dword_t nxt_ctrl_def;
  cfg_space_pkg::dword_t nxt_sticky_ctrl;
  cfg_space_pkg::dword_t nxt_count;
  cfg_space_pkg::dword_t nxt_log;
  cfg_space_pkg::dword_t nxt_rdata;
  cfg_space_pkg::dword_t count_step;
  cfg_space_pkg::dword_t count_base;

  // id only changes through the eeprom or a fundamental reset; software writes fall away
  assign nxt_id = eep_id ? i_eep_data : id_ff; // R1 R3

  wire logic ctrl_wr;
  wire logic sticky_ctrl_wr;
  wire logic count_rd;
  cfg_space_pkg::dword_t ctrl_merge;
  cfg_space_pkg::dword_t sticky_ctrl_merge;

  // only the enabled bytes of a write replace the stored ones
  assign ctrl_wr = acc.wr && sel_ctrl;
  assign sticky_ctrl_wr = acc.wr && sel_sticky_ctrl;
  assign count_rd = acc.rd && sel_count;
  assign ctrl_merge = (ctrl_ff & ~be_mask) | (i_cfg_wdata & be_mask);
  assign sticky_ctrl_merge = (sticky_ctrl_ff & ~be_mask) | (i_cfg_wdata & be_mask);

  assign nxt_ctrl_def = eep_ctrl ? i_eep_data : ctrl_def_ff; // R10
  assign nxt_ctrl = eep_ctrl ? i_eep_data : ctrl_wr ? ctrl_merge : ctrl_ff; // R5
  assign nxt_sticky_ctrl = sticky_ctrl_wr ? sticky_ctrl_merge : sticky_ctrl_ff; // R8

  // a read clears the tally, an event in the same cycle still counts
  assign count_base = count_rd ? `ZERO32 : count_ff; // R2
  // the tally stops at its top value instead of wrapping
  assign count_step = (count_base == `CNT_MAX) ? `ZERO32 : `CNT_ONE;
  assign nxt_count = i_count_evt ? (count_base + count_step) : count_base; // R2

  // hardware log: written by the device, never by software
  assign nxt_log = i_log_load ? i_log_val : log_ff; // R3 R4

  cfg_space_pkg::dword_t status_word;
  cfg_space_pkg::dword_t sticky_status_word;

  // status banks are narrower than a dword; the upper bits read zero
  assign status_word = {{(32-STATUS_W){1'b0}}, o_status};
  assign sticky_status_word = {{(32-STICKY_STATUS_W){1'b0}}, o_sticky_status};

  assign nxt_rdata = sel_id ? id_ff :
                     sel_ctrl ? ctrl_ff :
                     sel_sticky_ctrl ? sticky_ctrl_ff :
                     sel_status ? status_word :
                     sel_sticky_status ? sticky_status_word :
                     sel_count ? count_ff :
                     sel_log ? log_ff :
                     rom_hit ? rom_data :
                     `ZERO32; // R19

  // ----------------------------------------------------------------
  // fundamental-reset registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      id_ff <= {DEVICE_ID_DEF, VENDOR_ID_DEF}; // R1
    else
      id_ff <= nxt_id;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      ctrl_def_ff <= `RST_CTRL;
    else
      ctrl_def_ff <= nxt_ctrl_def;
  end

  // once up, ready stays up until the next fundamental reset
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      ready_ff <= 1'b0;
    else
      ready_ff <= ready_ff | i_eep_done; // R10
  end

  // ----------------------------------------------------------------
  // hot-reset registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      ctrl_ff <= `RST_CTRL;
    else if (i_hot_reset)
      ctrl_ff <= ctrl_def_ff;
    else
      ctrl_ff <= nxt_ctrl;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (nonsticky_clr)
      count_ff <= `ZERO32;
    else
      count_ff <= nxt_count;
  end

  // ----------------------------------------------------------------
  // sticky registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (sticky_clr)
      sticky_ctrl_ff <= `RST_STICKY_CTRL;
    else
      sticky_ctrl_ff <= nxt_sticky_ctrl; // R8
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (sticky_clr)
      log_ff <= `ZERO32;
    else
      log_ff <= nxt_log; // R4
  end

  // ----------------------------------------------------------------
  // answer
  // ----------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      ack_ff <= 1'b0;
    else
      ack_ff <= take;
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_reset_n)
      rdata_ff <= `ZERO32;
    else
      rdata_ff <= acc.rd ? nxt_rdata : `ZERO32;
  end

  assign o_cfg_ready = ready_ff;
  assign o_cfg_ack = ack_ff;
  assign o_cfg_rdata = rdata_ff;
  assign o_ctrl = ctrl_ff;
  assign o_sticky_ctrl = sticky_ctrl_ff;
endmodule

// ==== dv/cfg_chain_sva.sv ====
// checker on the configuration space ports
`timescale 1ns/1ps
module cfg_chain_sva
#(
  parameter int STATUS_W = 8,
  parameter int STICKY_STATUS_W = 8
)
(
  input wire logic i_sys_clk,
  input wire logic i_reset_n,
  input wire logic i_hot_reset,
  input wire logic i_cfg_req,
  input wire logic i_cfg_wr,
  input wire logic [11:2] i_cfg_addr,
  input wire logic o_cfg_ready,
  input wire logic o_cfg_ack,
  input wire logic [31:0] o_cfg_rdata,
  input wire logic i_eep_load,
  input wire logic [STATUS_W-1:0] i_status_set,
  input wire logic [STICKY_STATUS_W-1:0] i_sticky_status_set,
  input wire logic [31:0] o_ctrl,
  input wire logic [STATUS_W-1:0] o_status,
  input wire logic [STICKY_STATUS_W-1:0] o_sticky_status
);
  wire take = i_cfg_req && o_cfg_ready;
  wire rd = take && !i_cfg_wr;
  wire wr = take && i_cfg_wr;
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_reset_n);
  chk_ack_on_take: assert property (take |=> o_cfg_ack)
    else $error("ack missing");
  chk_no_stray_ack: assert property (!take |=> !o_cfg_ack)
    else $error("stray ack");
  chk_rdata_idle_zero: assert property (!o_cfg_ack |-> o_cfg_rdata == 32'h0000_0000)
    else $error("rdata not zero");
  chk_cap_ptr_val: assert property (
    rd && i_cfg_addr == 10'h00D |=> o_cfg_rdata == 32'h0000_0040) else $error("cap ptr");
  chk_dsn_header: assert property (
    rd && i_cfg_addr == 10'h040 |=> o_cfg_rdata == 32'hFB41_0003) else $error("dsn hdr");
  chk_aer_header: assert property (
    rd && i_cfg_addr == 10'h3ED |=> o_cfg_rdata == 32'h1381_0001) else $error("aer hdr");
  chk_vc_header: assert property (
    rd && i_cfg_addr == 10'h052 |=> o_cfg_rdata == 32'h0001_0002) else $error("vc hdr");
  chk_status_set_wins: assert property (
    !i_hot_reset |=> (o_status & $past(i_status_set)) == $past(i_status_set))
    else $error("status set lost");
  chk_sticky_status_hold: assert property (
    !(wr && i_cfg_addr == 10'h083) && !(|i_sticky_status_set) |=> $stable(o_sticky_status))
    else $error("sticky status moved");
  chk_ctrl_hold: assert property (
    !(wr && i_cfg_addr == 10'h080) && !i_hot_reset && !i_eep_load |=> $stable(o_ctrl))
    else $error("ctrl moved");
endmodule

// ==== dv/cfg_host_model.sv ====
// host model issuing configuration reads and writes
`timescale 1ns/1ps
module cfg_host_model
(
  input wire logic i_sys_clk,
  input wire logic i_ack,
  input wire logic [31:0] i_rdata,
  output logic o_req,
  output logic o_wr,
  output logic [11:2] o_addr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be
);
  initial
  begin
    o_req = 1'b0;
    o_wr = 1'b0;
    o_addr = 10'h3FF;
    o_wdata = 32'h0000_0000;
    o_be = 4'h0;
  end
  // one request for one taking edge, answer picked up in the cycle after
  task automatic xfer(input logic w, input logic [11:2] a, input logic [31:0] d,
    input logic [3:0] be, output logic k, output logic [31:0] q);
  begin
    @(posedge i_sys_clk);
    #2;
    o_req = 1'b1;
    o_wr = w;
    o_addr = a;
    o_wdata = d;
    o_be = be;
    @(posedge i_sys_clk);
    #2;
    o_req = 1'b0;
    // address and data lines stop showing the last value
    o_addr = ~a;
    o_wdata = ~d;
    k = i_ack;
    q = i_rdata;
  end
  endtask
endmodule

// ==== dv/tb.sv ====
// self-checking bench for the configuration space block
`timescale 1ns/1ps
module tb;
  logic i_sys_clk, i_reset_n, i_hot_reset, i_aux_keep, i_cfg_req, i_cfg_wr;
  logic o_cfg_ready, o_cfg_ack, i_eep_load, i_eep_done, i_count_evt, i_log_load;
  logic [11:2] i_cfg_addr, i_eep_addr;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, i_eep_data, i_log_val, o_ctrl, o_sticky_ctrl;
  logic [3:0] i_cfg_be;
  logic [7:0] i_status_set, i_sticky_status_set, o_status, o_sticky_status;
  int err_total = 0;
  int tests_run = 0;
  config_space_capability_chain uut
  (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hot_reset(i_hot_reset),
    .i_aux_keep(i_aux_keep), .i_cfg_req(i_cfg_req), .i_cfg_wr(i_cfg_wr),
    .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata), .i_cfg_be(i_cfg_be),
    .o_cfg_ready(o_cfg_ready), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .i_eep_load(i_eep_load), .i_eep_addr(i_eep_addr), .i_eep_data(i_eep_data),
    .i_eep_done(i_eep_done), .i_count_evt(i_count_evt), .i_status_set(i_status_set),
    .i_sticky_status_set(i_sticky_status_set), .i_log_load(i_log_load),
    .i_log_val(i_log_val), .o_ctrl(o_ctrl), .o_sticky_ctrl(o_sticky_ctrl),
    .o_status(o_status), .o_sticky_status(o_sticky_status)
  );
  cfg_host_model host (.i_sys_clk(i_sys_clk), .i_ack(o_cfg_ack), .i_rdata(o_cfg_rdata),
    .o_req(i_cfg_req), .o_wr(i_cfg_wr), .o_addr(i_cfg_addr), .o_wdata(i_cfg_wdata),
    .o_be(i_cfg_be));
  initial
  begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
  begin
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  end
  endtask
  task automatic end_sim;
  begin
    if (err_total == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task automatic step(input int n);
  begin
    repeat (n) @(posedge i_sys_clk);
    #2;
  end
  endtask
  task automatic xf(input logic w, input logic [11:2] a, input logic [31:0] v,
    input logic [3:0] be, input logic [31:0] exp);
    logic k;
    logic [31:0] d;
  begin
    host.xfer(w, a, v, be, k, d);
    chk({31'h0, k}, 32'h0000_0001);
    if (!w)
      chk(d, exp);
  end
  endtask
  task automatic boot(input logic ld);
    logic k;
    logic [31:0] d;
    int n;
  begin
    i_reset_n = 1'b0;
    step(20);
    i_reset_n = 1'b1;
    host.xfer(1'b0, 10'h00D, 32'h0000_0000, 4'hF, k, d);
    chk({31'h0, k}, 32'h0000_0000);
    i_eep_load = ld;
    i_eep_data = 32'hA1B2_C3D4;
    step(1);
    i_eep_addr = 10'h080;
    i_eep_data = 32'h0000_00A5;
    step(1);
    i_eep_load = 1'b0;
    i_eep_done = 1'b1;
    step(1);
    i_eep_done = 1'b0;
    n = 0;
    while (o_cfg_ready !== 1'b1 && n < 20)
    begin
      step(1);
      n++;
    end
    if (n == 20)
    begin
      err_total++;
      end_sim();
    end
    chk({31'h0, o_cfg_ready}, 32'h0000_0001);
  end
  endtask
  task automatic t_chain;
    logic [11:2] ad [10] = '{10'h00D, 10'h010, 10'h012, 10'h016, 10'h01A, 10'h040,
      10'h3ED, 10'h04E, 10'h052, 10'h021};
    logic [31:0] ex [10] = '{32'h0000_0040, 32'h0000_4801, 32'h0000_6805, 32'h0000_6807,
      32'h0000_0010, 32'hFB41_0003, 32'h1381_0001, 32'h1481_0004, 32'h0001_0002,
      32'h0000_0000};
  begin
    xf(1'b1, 10'h021, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000);
    xf(1'b1, 10'h00D, 32'h0000_0080, 4'hF, 32'h0000_0000);
    foreach (ad[i])
      xf(1'b0, ad[i], 32'h0000_0000, 4'hF, ex[i]);
  end
  endtask
  task automatic t_regs;
  begin
    xf(1'b1, 10'h000, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000);
    xf(1'b0, 10'h000, 32'h0000_0000, 4'hF, 32'hA1B2_C3D4);
    xf(1'b1, 10'h080, 32'h1234_5678, 4'h5, 32'h0000_0000);
    chk(o_ctrl, 32'h0034_0078);
    xf(1'b1, 10'h081, 32'hCAFE_F00D, 4'hF, 32'h0000_0000);
    chk(o_sticky_ctrl, 32'hCAFE_F00D);
    i_count_evt = 1'b1;
    i_status_set = 8'h0F;
    i_sticky_status_set = 8'h3C;
    i_log_load = 1'b1;
    step(1);
    {i_status_set, i_sticky_status_set, i_log_load} = 17'h0_0000;
    step(2);
    i_count_evt = 1'b0;
    chk({24'h0, o_status}, 32'h0000_000F);
    chk({24'h0, o_sticky_status}, 32'h0000_003C);
    xf(1'b0, 10'h084, 32'h0000_0000, 4'hF, 32'h0000_0003);
    xf(1'b0, 10'h084, 32'h0000_0000, 4'hF, 32'h0000_0000);
    xf(1'b1, 10'h082, 32'h0000_0005, 4'hF, 32'h0000_0000);
    xf(1'b0, 10'h082, 32'h0000_0000, 4'hF, 32'h0000_000A);
    xf(1'b1, 10'h083, 32'h0000_0000, 4'hF, 32'h0000_0000);
    xf(1'b1, 10'h083, 32'h0000_0004, 4'hF, 32'h0000_0000);
    chk({24'h0, o_sticky_status}, 32'h0000_0038);
    xf(1'b1, 10'h085, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000);
  end
  endtask
  task automatic t_sticky;
  begin
    i_hot_reset = 1'b1;
    step(1);
    i_hot_reset = 1'b0;
    xf(1'b0, 10'h080, 32'h0000_0000, 4'hF, 32'h0000_00A5);
    xf(1'b0, 10'h081, 32'h0000_0000, 4'hF, 32'hCAFE_F00D);
    xf(1'b0, 10'h085, 32'h0000_0000, 4'hF, 32'h5A5A_0001);
    i_aux_keep = 1'b1;
    boot(1'b0);
    xf(1'b0, 10'h083, 32'h0000_0000, 4'hF, 32'h0000_0038);
    xf(1'b0, 10'h081, 32'h0000_0000, 4'hF, 32'hCAFE_F00D);
    xf(1'b0, 10'h085, 32'h0000_0000, 4'hF, 32'h5A5A_0001);
    xf(1'b0, 10'h000, 32'h0000_0000, 4'hF, 32'h5678_1234);
  end
  endtask
  initial
  begin
    {i_reset_n, i_hot_reset, i_aux_keep, i_eep_load, i_eep_done, i_count_evt} = 6'h00;
    {i_status_set, i_sticky_status_set, i_log_load} = 17'h0_0000;
    i_eep_addr = 10'h000;
    i_eep_data = 32'h0000_0000;
    i_log_val = 32'h5A5A_0001;
    boot(1'b1);
    t_chain();
    t_regs();
    t_sticky();
    end_sim();
  end
endmodule
bind config_space_capability_chain cfg_chain_sva
  #(.STATUS_W(STATUS_W), .STICKY_STATUS_W(STICKY_STATUS_W)) sva
  (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_hot_reset(i_hot_reset),
    .i_cfg_req(i_cfg_req), .i_cfg_wr(i_cfg_wr), .i_cfg_addr(i_cfg_addr),
    .o_cfg_ready(o_cfg_ready), .o_cfg_ack(o_cfg_ack), .o_cfg_rdata(o_cfg_rdata),
    .i_eep_load(i_eep_load), .i_status_set(i_status_set),
    .i_sticky_status_set(i_sticky_status_set), .o_ctrl(o_ctrl), .o_status(o_status),
    .o_sticky_status(o_sticky_status)
  );
